// >>> core/stdc_diff_latch.sv
// Per-side holding latch for the upper bits of the time difference
`timescale 1ns/1ns

module stdc_diff_latch
  import stdc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        rd_en,
  input  wire logic        rd_low,
  input  wire logic [31:0] live_word,
  output logic      [31:0] read_word
);

  logic [31-DIFF_LOW_W:0] hold_reg;
  logic [31-DIFF_LOW_W:0] hold_next;

  // A low-byte read snapshots the upper bits for later reads
  always_comb
  begin
    hold_next = hold_reg;
    if (rd_en && rd_low)
      hold_next = live_word[31:DIFF_LOW_W];
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      hold_reg <= '0;
    else
      hold_reg <= hold_next;
  end

  // Upper-only reads return the snapshot, not the live value
  assign read_word = rd_low ? live_word
                            : {hold_reg, live_word[DIFF_LOW_W-1:0]};

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_low_snap: assert property (
    @(posedge clock) disable iff (!reset_n)
    rd_en && rd_low |=> hold_reg == $past(live_word[31:DIFF_LOW_W]))
    else $error("upper bits not caught on low byte read");

  a_snap_hold: assert property (
    @(posedge clock) disable iff (!reset_n)
    !(rd_en && rd_low) |=> $stable(hold_reg))
    else $error("snapshot moved without a low byte read");

endmodule

// >>> core/stdc_drift_ctrl.sv
// Drift control registers and time control loop, two access sides
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ns
// ***************************************************************
// How it works
// - Path delay: 32-bit word, resets zero, read and written by both sides.
// - Difference sign bit reads 0 while local copy lags received time.
// - Difference sign bit reads 1 while local copy is at or above it.
// - Difference low bits hold averaged magnitude; resets zero, read-only.
// - Low-byte read snapshots bits 31:8, one snapshot per side.
// - 15-bit bandwidth paces correction; larger means slower, smoother.
// - Bandwidth register resets to 0x1000.
// - An accepted bandwidth write clears difference and period deviation.
// - Bandwidth writes accepted only from the side owning system time.
// - Period deviation: 16-bit two's complement, read-only, resets zero.
// - Deviation stays within plus or minus bandwidth minus 0x7F.
// - Local copy is local time plus the stored offset.
// - Received time is compared with local copy, feeding the loop.
// - Averaging uses a 4-bit depth that resets to 4.
// ***************************************************************

module stdc_drift_ctrl
  import stdc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        net_wr,
  input  wire logic        net_rd,
  input  wire logic [15:0] net_addr,
  input  wire logic [3:0]  net_be,
  input  wire logic [31:0] net_wdata,
  output logic      [31:0] net_rdata,
  input  wire logic [31:0] sys_time_offset,
  input  wire logic        rx_time_valid,
  input  wire logic [31:0] rx_time,
  output logic      [31:0] sys_time_copy
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  stdc_rd_t            rd_state_reg, rd_state_next;
  logic                wr_pend_reg, wr_pend_next;
  logic [15:0]         h_addr_reg, h_addr_next;
  logic [31:0]         hrdata_reg, hrdata_next;
  logic [31:0]         net_rdata_reg, net_rdata_next;
  logic                h_acc;
  logic [31:0]         delay_reg, delay_next;
  logic [14:0]         bw_reg, bw_next;
  logic [3:0]          depth_reg, depth_next;
  logic                owner_reg, owner_next;
  logic                n_bw, h_bw, bw_wr;
  logic                n_depth, h_depth;
  logic [31:0]         local_reg, local_next;
  logic [31:0]         copy_reg, copy_next;
  logic signed [31:0]  mean_reg, mean_next;
  logic signed [31:0]  sample;
  logic                sign_reg, sign_next;
  logic signed [15:0]  dev_reg, dev_next;
  logic [14:0]         pace_reg, pace_next;
  logic [15:0]         corr_reg, corr_next;
  logic                tick, fire;
  logic signed [16:0]  lim_raw, lim, dev_x;
  logic [15:0]         dmag, step_at;
  logic [30:0]         mag;
  logic [31:0]         diff_word, h_diff, n_diff, bw_merged;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction

  // Unmapped offsets read as zero
  function automatic logic [31:0] rd_mux(
    input logic [15:0] a,
    input logic [31:0] dw
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == ADR_DELAY)
      r = delay_reg;
    else if (a == ADR_DIFF)
      r = dw;
    else if (a == ADR_BW)
      r = {17'h00000, bw_reg};
    else if (a == ADR_DEV)
      r = {16'h0000, dev_reg};
    else if (a == ADR_DEPTH)
      r = {28'h0000000, depth_reg};
    else if (a == ADR_OWN)
      r = {31'h00000000, owner_reg};
    return r;
  endfunction

  // ***************************************************************
  // Host side: AHB-Lite slave
  // ***************************************************************
  // Reads take one wait state so a write just before is visible
  assign h_acc = hsel && hready && htrans[1];
  always_comb
  begin
    rd_state_next = rd_state_reg;
    wr_pend_next  = h_acc && hwrite;
    h_addr_next   = h_acc ? haddr[15:0] : h_addr_reg;
    hrdata_next   = hrdata_reg;
    case (rd_state_reg)
      RD_IDLE:
      begin
        if (h_acc && !hwrite)
          rd_state_next = RD_WAIT;
      end
      RD_WAIT:
      begin
        hrdata_next   = rd_mux(h_addr_reg, h_diff);
        rd_state_next = RD_IDLE;
      end
      default:
        rd_state_next = RD_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      rd_state_reg <= RD_IDLE;
      wr_pend_reg  <= 1'b0;
      h_addr_reg   <= 16'h0000;
      hrdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      wr_pend_reg  <= wr_pend_next;
      h_addr_reg   <= h_addr_next;
      hrdata_reg   <= hrdata_next;
    end
  end

  assign hreadyout = (rd_state_reg != RD_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // ***************************************************************
  // Network side: strobe port, read data one cycle later
  // ***************************************************************
  // A process, not an assign, so register changes reach the mux
  always_comb
  begin
    net_rdata_next = net_rdata_reg;
    if (net_rd)
      net_rdata_next = rd_mux(net_addr, n_diff);
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      net_rdata_reg <= 32'h0000_0000;
    else
      net_rdata_reg <= net_rdata_next;
  end

  assign net_rdata = net_rdata_reg;

  // ***************************************************************
  // Difference snapshots, one per side
  // ***************************************************************
  stdc_diff_latch u_host_latch (
    .clock     (clock),
    .reset_n   (reset_n),
    .rd_en     ((rd_state_reg == RD_WAIT) && (h_addr_reg == ADR_DIFF)),
    .rd_low    (1'b1),
    .live_word (diff_word),
    .read_word (h_diff)
  );

  stdc_diff_latch u_net_latch (
    .clock     (clock),
    .reset_n   (reset_n),
    .rd_en     (net_rd && (net_addr == ADR_DIFF)),
    .rd_low    (net_be[0]),
    .live_word (diff_word),
    .read_word (n_diff)
  );

  // ***************************************************************
  // Register writes
  // ***************************************************************
  // Loop registers are absent from the write decode, so writes to them
  // fall away. Network wins if both sides write the path delay the same cycle; for bandwidth and depth the owner's write is taken.
  always_comb
  begin
    n_bw    = net_wr && (net_addr == ADR_BW) && (|net_be[1:0])
              && !owner_reg;
    h_bw    = wr_pend_reg && (h_addr_reg == ADR_BW) && owner_reg;
    n_depth = net_wr && (net_addr == ADR_DEPTH) && net_be[0]
              && !owner_reg;
    h_depth = wr_pend_reg && (h_addr_reg == ADR_DEPTH) && owner_reg;
    bw_wr   = n_bw || h_bw;
    delay_next = delay_reg;
    if (net_wr && (net_addr == ADR_DELAY))
      delay_next = merge(delay_reg, net_wdata, net_be);
    else if (wr_pend_reg && (h_addr_reg == ADR_DELAY))
      delay_next = hwdata;
    // Bit 15 is not stored; software keeps it at zero
    bw_merged = merge({17'h00000, bw_reg}, net_wdata, net_be);
    bw_next = bw_reg;
    if (n_bw)
      bw_next = bw_merged[14:0];
    else if (h_bw)
      bw_next = hwdata[14:0];
    depth_next = depth_reg;
    if (n_depth)
      depth_next = net_wdata[3:0];
    else if (h_depth)
      depth_next = hwdata[3:0];
    // Ownership is a network-side setting
    owner_next = owner_reg;
    if (net_wr && (net_addr == ADR_OWN) && net_be[0])
      owner_next = net_wdata[0];
  end

  // ***************************************************************
  // Time control loop
  // ***************************************************************
  always_comb
  begin
    copy_next = local_reg + sys_time_offset;
    sample    = $signed(rx_time - copy_reg);
    // Running mean; depth sets the weight of each new sample
    mean_next = mean_reg;
    sign_next = sign_reg;
    if (bw_wr)
    begin
      mean_next = 32'sh0000_0000;
      sign_next = 1'b0;
    end
    else if (rx_time_valid)
    begin
      mean_next = mean_reg + ((sample - mean_reg) >>> depth_reg);
      sign_next = (mean_next <= 32'sh0000_0000);
    end
    mag       = mean_reg[31] ? 31'(-mean_reg) : mean_reg[30:0];
    diff_word = {sign_reg, mag};
    // Deviation moves one step per bandwidth period
    tick      = (pace_reg >= bw_reg);
    pace_next = tick ? 15'h0000 : pace_reg + 15'h0001;
    lim_raw   = $signed({2'b00, bw_reg}) - $signed(DEV_MARGIN);
    lim       = lim_raw[16] ? 17'sh00000 : lim_raw;
    dev_x     = {dev_reg[15], dev_reg};
    dev_next  = dev_reg;
    if (bw_wr)
      dev_next = 16'sh0000;
    else if (tick && (mean_reg > 0) && (dev_x < lim))
      dev_next = dev_reg + 16'sh0001;
    else if (tick && (mean_reg < 0) && (dev_x > -lim))
      dev_next = dev_reg - 16'sh0001;
    // A larger deviation corrects more often; larger bandwidth less
    dmag      = dev_reg[15] ? 16'(-dev_reg) : dev_reg;
    step_at   = {1'b0, bw_reg} - dmag;
    fire      = (corr_reg >= step_at) && (dev_reg != 16'sh0000);
    corr_next = (corr_reg >= step_at) ? 16'h0000 : corr_reg + 16'h0001;
    local_next = local_reg + 32'(TICK_NS);
    if (fire)
      local_next = dev_reg[15] ? local_reg + 32'(TICK_NS) - 32'h0000_0001
                               : local_reg + 32'(TICK_NS) + 32'h0000_0001;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      delay_reg <= DELAY_RESET;
      bw_reg    <= BW_RESET;
      depth_reg <= DEPTH_RESET;
      owner_reg <= 1'b0;
      local_reg <= 32'h0000_0000;
      copy_reg  <= 32'h0000_0000;
      mean_reg  <= 32'sh0000_0000;
      sign_reg  <= 1'b0;
      dev_reg   <= 16'sh0000;
      pace_reg  <= 15'h0000;
      corr_reg  <= 16'h0000;
    end
    else
    begin
      delay_reg <= delay_next;
      bw_reg    <= bw_next;
      depth_reg <= depth_next;
      owner_reg <= owner_next;
      local_reg <= local_next;
      copy_reg  <= copy_next;
      mean_reg  <= mean_next;
      sign_reg  <= sign_next;
      dev_reg   <= dev_next;
      pace_reg  <= pace_next;
      corr_reg  <= corr_next;
    end
  end

  assign sys_time_copy = copy_reg;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence s_rd_take;
    h_acc && !hwrite;
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  a_host_read: assert property (s_rd_take |=> s_rd_answer)
    else $error("host read did not answer after one wait state");
  a_bw_reset: assert property (
    $rose(reset_n) |-> bw_reg == BW_RESET)
    else $error("bandwidth not at reset value");
  a_depth_reset: assert property (
    $rose(reset_n) |-> depth_reg == DEPTH_RESET)
    else $error("averaging depth not at reset value");
  a_bw_clears: assert property (
    bw_wr |=> mean_reg == 0 && dev_reg == 0 && !sign_reg)
    else $error("bandwidth write left loop state");
  a_owner_gate: assert property (
    net_wr && net_addr == ADR_BW && owner_reg && !h_bw
    |=> $stable(bw_reg))
    else $error("bandwidth taken from side without ownership");
  a_dev_range: assert property (
    dev_x <= lim && dev_x >= -lim)
    else $error("deviation outside its range");
  a_sign_flag: assert property (
    rx_time_valid && !bw_wr |=> sign_reg == (mean_reg <= 0))
    else $error("sign bit disagrees with mean");
  a_delay_write: assert property (
    net_wr && net_addr == ADR_DELAY && net_be == 4'hF
    |=> delay_reg == $past(net_wdata))
    else $error("path delay write lost");
  a_ro_ignore: assert property (
    net_wr && net_addr == ADR_DEV && !tick && !bw_wr
    |=> $stable(dev_reg))
    else $error("write changed read-only deviation");

endmodule

// >>> core/stdc_pkg.sv
// Shared constants and types for the system time drift control block
package stdc_pkg;

  // ***************************************************************
  // Clock and local time step
  // ***************************************************************
  localparam int unsigned CLK_FREQ_MHZ = 50;
  localparam int unsigned TICK_NS      = 1000 / CLK_FREQ_MHZ;

  // ***************************************************************
  // Register indices as printed; byte address is four times each
  // ***************************************************************
  localparam logic [15:0] IDX_DELAY = 16'h0928;
  localparam logic [15:0] IDX_DIFF  = 16'h092C;
  localparam logic [15:0] IDX_BW    = 16'h0930;
  localparam logic [15:0] IDX_DEV   = 16'h0932;
  localparam logic [15:0] IDX_DEPTH = 16'h0934;
  localparam logic [15:0] IDX_OWN   = 16'h0938;

  localparam logic [15:0] ADR_DELAY = IDX_DELAY << 2;
  localparam logic [15:0] ADR_DIFF  = IDX_DIFF << 2;
  localparam logic [15:0] ADR_BW    = IDX_BW << 2;
  localparam logic [15:0] ADR_DEV   = IDX_DEV << 2;
  localparam logic [15:0] ADR_DEPTH = IDX_DEPTH << 2;
  localparam logic [15:0] ADR_OWN   = IDX_OWN << 2;

  // ***************************************************************
  // Reset values and field limits
  // ***************************************************************
  localparam logic [31:0] DELAY_RESET = 32'h0000_0000;
  localparam logic [14:0] BW_RESET    = 15'h1000;
  localparam logic [16:0] DEV_MARGIN  = 17'h0007F;
  localparam logic [3:0]  DEPTH_RESET = 4'h4;
  localparam int unsigned DIFF_LOW_W  = 8;

  typedef enum logic [0:0]
  {
    RD_IDLE = 1'b0,
    RD_WAIT = 1'b1
  } stdc_rd_t;

endpackage

// >>> tb/testbench.sv
// Self-checking bench for the drift control registers and time loop
`timescale 1ns/1ns

module testbench;
  import stdc_pkg::*;
  // ***************************************************************
  // Signals and design instance
  // ***************************************************************
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        net_wr = 1'b0;
  logic        net_rd = 1'b0;
  logic [15:0] net_addr = 16'h0000;
  logic [3:0]  net_be = 4'h0;
  logic [31:0] net_wdata = 32'h0000_0000;
  logic [31:0] net_rdata;
  logic [31:0] sys_time_offset = 32'h0000_0000;
  logic        rx_time_valid = 1'b0;
  logic [31:0] rx_time = 32'h0000_0000;
  logic [31:0] sys_time_copy;
  int          fails = 0;
  int          n_tests = 0;
  logic [31:0] w1, w2, w3, c1;

  always #10 clock = ~clock;

  stdc_drift_ctrl uut
  (
    .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .net_wr(net_wr), .net_rd(net_rd),
    .net_addr(net_addr), .net_be(net_be), .net_wdata(net_wdata),
    .net_rdata(net_rdata), .sys_time_offset(sys_time_offset),
    .rx_time_valid(rx_time_valid), .rx_time(rx_time),
    .sys_time_copy(sys_time_copy)
  );

  // ***************************************************************
  // Access tasks and checks
  // ***************************************************************
  task automatic complete_run;
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  // Ready only moves on rising edges, so the value seen mid-cycle is the
  // one the next edge samples; only the watchdog ends a hung wait
  task automatic wait_ready(input int exp_w);
    int n;
    n = 0;
    @(negedge clock);
    while (hreadyout !== 1'b1)
    begin
      n++;
      @(negedge clock);
    end
    chk("wait states", 32'(exp_w), 32'(n));
    chk("hresp", 32'h0, {31'h0, hresp});
    @(posedge clock);
  endtask

  task automatic ahb(input logic wr, input logic [15:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {16'h0000, a};
    hwrite <= wr;
    wait_ready(0);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(wr ? 0 : 1);
    rd = hrdata;
  endtask

  task automatic net(input logic wr, input logic [15:0] a,
                     input logic [3:0] be, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock);
    net_wr    <= wr;
    net_rd    <= ~wr;
    net_addr  <= a;
    net_be    <= be;
    net_wdata <= wd;
    @(posedge clock);
    net_wr <= 1'b0;
    net_rd <= 1'b0;
    @(negedge clock);
    rd = net_rdata;
  endtask

  // Received time is placed relative to the local copy seen mid-cycle;
  // the copy moves one tick more before the sample is compared
  task automatic send_rx(input logic [31:0] delta);
    logic [31:0] seen;
    @(negedge clock);
    seen = sys_time_copy;
    @(posedge clock);
    rx_time       <= seen + delta;
    rx_time_valid <= 1'b1;
    @(posedge clock);
    rx_time_valid <= 1'b0;
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    ahb(0, ADR_DELAY, 0, w1); chk("delay rst", 32'h0, w1);
    ahb(0, ADR_DIFF, 0, w1); chk("diff rst", 32'h0, w1);
    ahb(0, ADR_BW, 0, w1); chk("bw rst", 32'h1000, w1);
    ahb(0, ADR_DEV, 0, w1); chk("dev rst", 32'h0, w1);
    ahb(0, ADR_DEPTH, 0, w1); chk("depth rst", 32'h4, w1);
    ahb(1, ADR_DELAY, 32'hA5A5_5A5A, w1);
    net(0, ADR_DELAY, 4'hF, 0, w1); chk("delay", 32'hA5A5_5A5A, w1);
    net(1, ADR_DELAY, 4'hF, 32'h1234_5678, w1);
    net(1, ADR_DELAY, 4'h1, 32'h0000_00FF, w1);
    ahb(0, ADR_DELAY, 0, w1); chk("delay", 32'h1234_56FF, w1);
    ahb(1, ADR_DIFF, 32'hFFFF_FFFF, w1);
    net(1, ADR_DEV, 4'hF, 32'hFFFF_FFFF, w1);
    ahb(0, ADR_DIFF, 0, w1); chk("diff ro", 32'h0, w1);
    net(0, ADR_DEV, 4'hF, 0, w1); chk("dev ro", 32'h0, w1);
    ahb(0, 16'h0100, 0, w1); chk("unmapped", 32'h0, w1);
    // Network owns system time after reset
    ahb(1, ADR_BW, 32'h0000_0300, w1);
    ahb(0, ADR_BW, 0, w1); chk("bw host", 32'h1000, w1);
    net(1, ADR_BW, 4'hF, 32'h0000_0080, w1);
    ahb(0, ADR_BW, 0, w1); chk("bw net", 32'h0080, w1);
    net(1, ADR_OWN, 4'hF, 32'h1, w1);
    ahb(1, ADR_BW, 32'h0000_3FFF, w1);
    net(1, ADR_BW, 4'hF, 32'h0000_0200, w1);
    ahb(0, ADR_BW, 0, w1); chk("bw owner", 32'h3FFF, w1);
    ahb(1, ADR_BW, 32'h0000_0080, w1);
    // Local copy ahead of received time by 100000 ns, depth 4
    send_rx(32'hFFFE_7960);
    ahb(0, ADR_DIFF, 0, w1); chk("diff sign", 32'h1, {31'h0, w1[31]});
    chk("diff mag", 32'h1, {31'h0, w1[30:0] > 31'd6000 && w1[30:0] < 31'd6500});
    net(0, ADR_DIFF, 4'hF, 0, w1);
    send_rx(32'hFFFE_7960);
    net(0, ADR_DIFF, 4'hE, 0, w2); chk("snap", w1 >> 8, w2 >> 8);
    net(0, ADR_DIFF, 4'hF, 0, w3);
    chk("live", 32'h1, {31'h0, w3[30:8] != w1[30:8]});
    ahb(1, ADR_DIFF, 32'h0, w2);
    ahb(0, ADR_DIFF, 0, w2); chk("host diff", w3, w2);
    repeat (700) @(posedge clock);
    ahb(0, ADR_DEV, 0, w1);
    // Mean is negative, so deviation runs down to its clamp of -1
    chk("dev range", 32'h0000_FFFF, w1);
    ahb(1, ADR_BW, 32'h0000_0100, w1);
    ahb(0, ADR_DIFF, 0, w1); chk("diff clr", 32'h0, w1);
    ahb(0, ADR_DEV, 0, w1); chk("dev clr", 32'h0, w1);
    // Depth 2 lets one sample carry a quarter of its weight
    ahb(1, ADR_DEPTH, 32'h0000_0002, w1);
    ahb(0, ADR_DEPTH, 0, w1); chk("depth", 32'h2, w1);
    send_rx(32'h0001_86A0);
    ahb(0, ADR_DIFF, 0, w1); chk("diff pos", 32'h0, {31'h0, w1[31]});
    chk("diff pos mag", 32'h1,
        {31'h0, w1[30:0] > 31'd24000 && w1[30:0] < 31'd26000});
    // Offset step shows up in the local copy on top of the tick
    @(negedge clock);
    c1 = sys_time_copy;
    @(posedge clock);
    sys_time_offset <= 32'h0001_0000;
    repeat (3) @(negedge clock);
    w1 = sys_time_copy - c1;
    chk("copy", 32'h1, {31'h0, w1 > 32'h0001_0000 && w1 < 32'h0001_0060});
    complete_run();
  end

  // ***************************************************************
  // Watchdog
  // ***************************************************************
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    complete_run();
  end

endmodule
